/* shared/btx_defs.vh */
// Constants for the burst transmit output timing block
`ifndef BTX_DEFS_VH
`define BTX_DEFS_VH

// ========================================
// AXI4-Lite register byte offsets
`define BTX_REG_AUX_DIV 8'h00
`define BTX_REG_BIT_DIV 8'h04
`define BTX_REG_MODE 8'h08
`define BTX_REG_STATUS 8'h0C

// ========================================
// Field positions
`define BTX_MODE_SLAVE_BIT 7
`define BTX_MODE_RS_BIT 6
`define BTX_MODE_MOD_LSB 0
`define BTX_MODE_MOD_MSB 1

// ========================================
// Reset values
`define BTX_AUX_DIV_RST 4'h2
`define BTX_BIT_DIV_RST 12'h003
`define BTX_MODE_RST 8'h01

// ========================================
// Modulation codes
`define BTX_MOD_BPSK 2'h0
`define BTX_MOD_QPSK 2'h1
`define BTX_MOD_QAM16 2'h2

// ========================================
// Timing counts, in main clock cycles or symbol pulses
`define BTX_AUX_HIGH_CYC 2
`define BTX_ON_DELAY 5'h02
`define BTX_OFF_DELAY 5'h0D
`define BTX_RS_BPSK 5'h08
`define BTX_RS_QPSK 5'h04
`define BTX_RS_QAM16 5'h02

`endif

/* design/btx_sync3.v */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module btx_sync3
(
    input wire clk, // Main clock
    input wire rst, // Asynchronous reset
    input wire din, // Asynchronous input
    output reg dout // Filtered level
);
    reg s1;
    reg s2;
    reg s3;

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            dout <= 1'b0;
        end
        else
        begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3)
                dout <= s3;
        end
    end
endmodule

/* design/btx_aux_clock.v */
// Auxiliary clock generator: two cycles high, n-1 cycles low
`timescale 1ns/1ns
`include "btx_defs.vh"
module btx_aux_clock
(
    input wire clk, // Main clock
    input wire rst, // Asynchronous reset
    input wire [3:0] div_n, // Divider setting n
    output reg aux_clock_out // Auxiliary clock
);
    reg [3:0] cnt;
    wire [3:0] low_len;

    // Low phase at least one cycle
    assign low_len = (div_n < 4'h2) ? 4'h1 : div_n - 4'h1;

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt <= 4'h0;
            aux_clock_out <= 1'b0;
        end
        else if (aux_clock_out)
        begin
            if (cnt >= `BTX_AUX_HIGH_CYC - 1)
            begin
                aux_clock_out <= 1'b0;
                cnt <= 4'h0;
            end
            else
                cnt <= cnt + 4'h1;
        end
        else
        begin
            if (cnt >= low_len - 4'h1)
            begin
                aux_clock_out <= 1'b1;
                cnt <= 4'h0;
            end
            else
                cnt <= cnt + 4'h1;
        end
    end
endmodule

/* design/btx_output_timing.v */
// Burst transmit output timing with AXI4-Lite configuration registers
//
// What this block does
// - Auxiliary clock output stays high for two main clock cycles.
// - Auxiliary clock low phase lasts n-1 cycles, n from divider register.
// - Symbol pulse is high for exactly one main clock cycle per symbol.
// - Transmit-enable output changes one cycle after bit clock goes low.
// - Without pipelining, output rises at second symbol pulse after input rises.
// - Without pipelining, output falls at thirteenth symbol pulse after input falls.
// - Pipelining adds 8, 4 or 2 symbol pulses for BPSK, QPSK, 16QAM.
// - Pipeline bit zero is minimum delay; Reed-Solomon then unusable.
// - In slave mode output edges follow host bit clock and stall if it stops.
// - In QPSK slave burst output rises at end of second symbol.
// - Mode bit seven selects slave (host clock) or master timing.
// - Inputs are latched on the main clock edge after bit clock falls.
// - Bit clock forced high six main edges after host clock pin rises (two after the synchronised rise).
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ns
`include "btx_defs.vh"
module btx_output_timing
(
    input wire clk, // Main clock, 10 MHz
    input wire rst, // Asynchronous reset, active high
    input wire host_bit_clock, // Host bit clock pin
    input wire tx_enable_in, // Burst enable from host
    input wire clock_gate_enable, // Clock gate from host
    input wire diff_encode_enable, // Differential encode enable
    input wire fec_encode_enable, // Reed-Solomon encode enable
    input wire scrambler_enable, // Scrambler enable
    input wire tx_data_in, // Serial data from host
    output reg aux_clock_out, // Auxiliary clock
    output reg symbol_pulse, // One-cycle symbol strobe
    output reg bit_clock_out, // Bit clock
    output reg tx_enable_out, // Delayed transmit enable
    output reg [4:0] latched_ctrl, // Latched data and enables
    input wire [7:0] s_axi_awaddr, // Write address
    input wire s_axi_awvalid, // Write address valid
    output reg s_axi_awready, // Write address ready
    input wire [31:0] s_axi_wdata, // Write data
    input wire [3:0] s_axi_wstrb, // Write strobes
    input wire s_axi_wvalid, // Write data valid
    output reg s_axi_wready, // Write data ready
    output reg [1:0] s_axi_bresp, // Write response
    output reg s_axi_bvalid, // Write response valid
    input wire s_axi_bready, // Write response ready
    input wire [7:0] s_axi_araddr, // Read address
    input wire s_axi_arvalid, // Read address valid
    output reg s_axi_arready, // Read address ready
    output reg [31:0] s_axi_rdata, // Read data
    output reg [1:0] s_axi_rresp, // Read response
    output reg s_axi_rvalid, // Read data valid
    input wire s_axi_rready // Read data ready
);
    // ========================================
    // Configuration registers
    reg [3:0] aux_div;
    reg [11:0] bit_div;
    reg [7:0] mode_reg;
    reg [7:0] aw_addr;
    reg aw_have;
    reg w_have;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    wire host_clk_s;
    wire tx_enable_in_s;

    wire slave_mode = mode_reg[`BTX_MODE_SLAVE_BIT];
    wire rs_pipe = mode_reg[`BTX_MODE_RS_BIT];
    wire [1:0] mod_sel = mode_reg[`BTX_MODE_MOD_MSB:`BTX_MODE_MOD_LSB];

    // ========================================
    // Write channel: address and data in either order
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            aw_have <= 1'b0;
            w_have <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            aux_div <= `BTX_AUX_DIV_RST;
            bit_div <= `BTX_BIT_DIV_RST;
            mode_reg <= `BTX_MODE_RST;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_addr <= s_axi_awaddr;
                aw_have <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                w_have <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (aw_have && w_have && !s_axi_bvalid)
            begin
                aw_have <= 1'b0;
                w_have <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'h0;
                case (aw_addr)
                    `BTX_REG_AUX_DIV:
                        if (w_strb[0])
                            aux_div <= w_data[3:0];
                    `BTX_REG_BIT_DIV:
                    begin
                        if (w_strb[0])
                            bit_div[7:0] <= w_data[7:0];
                        if (w_strb[1])
                            bit_div[11:8] <= w_data[11:8];
                    end
                    `BTX_REG_MODE:
                        if (w_strb[0])
                            mode_reg <= w_data[7:0];
                    `BTX_REG_STATUS:
                        s_axi_bresp <= 2'h0;
                    default:
                        s_axi_bresp <= 2'h2;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ========================================
    // Read channel
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end
        else if (s_axi_rvalid)
        begin
            if (s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            case (s_axi_araddr)
                `BTX_REG_AUX_DIV:
                    s_axi_rdata <= {28'h0000000, aux_div};
                `BTX_REG_BIT_DIV:
                    s_axi_rdata <= {20'h00000, bit_div};
                `BTX_REG_MODE:
                    s_axi_rdata <= {24'h000000, mode_reg};
                `BTX_REG_STATUS:
                    s_axi_rdata <= {27'h0000000, tx_enable_in_s,
                        host_clk_s, tx_enable_out, bit_clock_out,
                        symbol_pulse};
                default:
                begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end
    end

    // ========================================
    // Input synchronisers
    btx_sync3 u_sync_clk
    (
        .clk(clk),
        .rst(rst),
        .din(host_bit_clock),
        .dout(host_clk_s)
    );

    btx_sync3 u_sync_en
    (
        .clk(clk),
        .rst(rst),
        .din(tx_enable_in),
        .dout(tx_enable_in_s)
    );

    // ========================================
    // Auxiliary clock
    wire aux_q;

    btx_aux_clock u_aux
    (
        .clk(clk),
        .rst(rst),
        .div_n(aux_div),
        .aux_clock_out(aux_q)
    );

    always @(posedge clk or posedge rst)
    begin
        if (rst)
            aux_clock_out <= 1'b0;
        else
            aux_clock_out <= aux_q;
    end

    // ========================================
    // Bit clock and symbol pulse
    reg host_clk_d;
    reg host_rise_d;
    reg [11:0] bit_cnt;
    reg [1:0] bits_in_sym;
    wire host_rise = host_clk_s && !host_clk_d;
    wire [1:0] bits_per_sym = (mod_sel == `BTX_MOD_BPSK) ? 2'h0 :
        (mod_sel == `BTX_MOD_QPSK) ? 2'h1 : 2'h3;
    wire bit_fall = bit_clock_out && (bit_cnt == 12'h000);

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            host_clk_d <= 1'b0;
            host_rise_d <= 1'b0;
            bit_cnt <= 12'h000;
            bit_clock_out <= 1'b0;
            bits_in_sym <= 2'h0;
            symbol_pulse <= 1'b0;
        end
        else
        begin
            host_clk_d <= host_clk_s;
            host_rise_d <= host_rise;
            symbol_pulse <= 1'b0;
            if (slave_mode && host_rise_d)
            begin
                bit_clock_out <= 1'b1;
                bit_cnt <= bit_div;
            end
            else if (bit_cnt != 12'h000)
                bit_cnt <= bit_cnt - 12'h001;
            else if (bit_clock_out)
            begin
                bit_clock_out <= 1'b0;
                bit_cnt <= bit_div;
                if (bits_in_sym >= bits_per_sym)
                begin
                    bits_in_sym <= 2'h0;
                    symbol_pulse <= 1'b1;
                end
                else
                    bits_in_sym <= bits_in_sym + 2'h1;
            end
            else if (!slave_mode)
            begin
                bit_clock_out <= 1'b1;
                bit_cnt <= bit_div;
            end
        end
    end

    // ========================================
    // Input latch after each bit clock fall
    reg bit_fell;

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            bit_fell <= 1'b0;
            latched_ctrl <= 5'h00;
        end
        else
        begin
            bit_fell <= bit_fall;
            if (bit_fell)
                latched_ctrl <= {tx_data_in, clock_gate_enable,
                    diff_encode_enable, fec_encode_enable, scrambler_enable};
        end
    end

    // ========================================
    // Transmit-enable delay in symbol pulses
    reg en_state;
    reg [4:0] sym_cnt;
    wire [4:0] rs_extra = !rs_pipe ? 5'h00 :
        (mod_sel == `BTX_MOD_BPSK) ? `BTX_RS_BPSK :
        (mod_sel == `BTX_MOD_QPSK) ? `BTX_RS_QPSK : `BTX_RS_QAM16;

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            en_state <= 1'b0;
            sym_cnt <= 5'h00;
            tx_enable_out <= 1'b0;
        end
        else
        begin
            // Counter steps only on symbol pulses, so in slave mode a stopped host clock
            // also holds off the burst end
            if (tx_enable_in_s != en_state)
            begin
                en_state <= tx_enable_in_s;
                sym_cnt <= (tx_enable_in_s ? `BTX_ON_DELAY :
                    `BTX_OFF_DELAY) + rs_extra;
            end
            else if (symbol_pulse && sym_cnt != 5'h00)
            begin
                sym_cnt <= sym_cnt - 5'h01;
                // Pulse stands one cycle after bit clock fell, so the
                // edge lands on the counted pulse
                if (sym_cnt == 5'h01 && bit_fell)
                    tx_enable_out <= en_state;
            end
        end
    end
endmodule

/* sim/btx_output_monitor.sv */
// Port checker for the burst transmit output timing block
`timescale 1ns/1ns
module btx_output_monitor
(
    input wire clk, // Main clock
    input wire rst, // Reset
    input wire aux_clock_out, // Aux clock
    input wire symbol_pulse, // Symbol strobe
    input wire bit_clock_out, // Bit clock
    input wire tx_enable_out, // Tx enable out
    input wire [4:0] latched_ctrl, // Latched inputs
    input wire s_axi_awready, // Aw ready
    input wire s_axi_bvalid, // B valid
    input wire s_axi_arvalid, // Ar valid
    input wire s_axi_arready, // Ar ready
    input wire s_axi_rvalid, // R valid
    input wire s_axi_rready, // R ready
    input wire [1:0] s_axi_rresp // R response
);
// ========================================
// Bit clock history
reg [1:0] bit_hist;
always @(posedge clk or posedge rst)
begin
    if (rst)
        bit_hist <= 2'h0;
    else
        bit_hist <= {bit_hist[0], bit_clock_out};
end
default clocking mon_cb @(posedge clk);
endclocking
default disable iff (rst);
// ========================================
// Properties
aux_high_a:
    assert property ($rose(aux_clock_out) |=> aux_clock_out ##1
        !aux_clock_out) else $error("aux clock high phase wrong");
aux_low_a:
    assert property ($fell(aux_clock_out) |-> ##[1:14] aux_clock_out)
        else $error("aux clock low phase too long");
sym_once_a:
    assert property (symbol_pulse |=> !symbol_pulse)
        else $error("symbol pulse too long");
txen_edge_a:
    assert property ($changed(tx_enable_out) |-> $past(bit_clock_out, 2)
        && !$past(bit_clock_out)) else $error("tx enable edge misplaced");
latch_time_a:
    assert property ($changed(latched_ctrl) |-> bit_hist == 2'h2)
        else $error("inputs latched at wrong time");
rd_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
        && !s_axi_arready) else $error("read answer wrong");
rd_done_a:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer not retired");
wr_block_a:
    assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write taken during answer");
cover property ($rose(tx_enable_out));
cover property ($fell(tx_enable_out));
cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule
bind btx_output_timing btx_output_monitor mon_u
(
    .clk, .rst, .aux_clock_out, .symbol_pulse, .bit_clock_out,
    .tx_enable_out, .latched_ctrl, .s_axi_awready, .s_axi_bvalid,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rresp
);

/* sim/btx_host_model.sv */
// Host burst controller model: serial data and control strobes
`timescale 1ns/1ns
module btx_host_model
(
    input wire master, // Follow device bit clock
    input wire start, // Begin a burst
    input wire [2:0] bps, // Bits per symbol
    input wire bit_clock_out, // Device bit clock
    input wire tx_enable_out, // Device tx enable
    output reg host_bit_clock = 1'b0, // Own bit clock
    output reg tx_enable_in = 1'b0, // Burst enable
    output reg clock_gate_enable = 1'b0, // Clock gate
    output reg diff_encode_enable = 1'b0, // Diff enable
    output reg fec_encode_enable = 1'b0, // Encode enable
    output reg scrambler_enable = 1'b0, // Scrambler enable
    output reg tx_data_in = 1'b0 // Serial data
);
localparam HALF_NS = 800;
reg run = 1'b0;
reg [31:0] rnd;
integer b, p, l;
wire bclk = master ? bit_clock_out : host_bit_clock;
// ========================================
// Own clock, still outside bursts
always
begin
    wait (run && !master);
    #(HALF_NS) host_bit_clock = 1'b1;
    #(HALF_NS) host_bit_clock = 1'b0;
end
// ========================================
// Burst sequence
always @(posedge start)
begin
    run = 1'b1;
    p = 14 * bps;
    l = p + 8 * bps;
    for (b = 0; b <= l; b = b + 1)
    begin
        @(negedge bclk) #10;
        rnd = $urandom;
        tx_data_in = (b < l) ? rnd[0] : !tx_data_in;
        clock_gate_enable = 1'b1;
        @(posedge bclk) #10;
        if (b == 0)
            tx_enable_in = 1'b1;
        if (b == p - bps)
            diff_encode_enable = 1'b1;
        if (b == p)
            {fec_encode_enable, scrambler_enable} = 2'h3;
        if (b == l - bps)
            {diff_encode_enable, fec_encode_enable} = 2'h0;
        if (b == l)
            {tx_enable_in, scrambler_enable} = 2'h0;
    end
    wait (!tx_enable_out);
    run = 1'b0;
    clock_gate_enable = 1'b0;
end
endmodule

/* sim/tb_top.sv */
// Self-checking bench for the burst transmit output timing block
`timescale 1ns/1ns
`include "btx_defs.vh"
module tb_top;
reg clk = 1'b0;
reg rst = 1'b1;
reg m_master = 1'b0;
reg m_start = 1'b0;
reg [2:0] m_bps = 3'h1;
reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
reg [31:0] s_axi_wdata = 32'h0;
reg [3:0] s_axi_wstrb = 4'hF;
reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
reg s_axi_arvalid = 0, s_axi_rready = 0;
reg [31:0] rq;
reg [1:0] rr;
integer errors = 0, samples_checked = 0, cyc = 0, i;
wire host_bit_clock, tx_enable_in, clock_gate_enable, diff_encode_enable;
wire fec_encode_enable, scrambler_enable, tx_data_in, aux_clock_out;
wire symbol_pulse, bit_clock_out, tx_enable_out, s_axi_awready;
wire s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
wire [1:0] s_axi_bresp, s_axi_rresp;
wire [4:0] latched_ctrl;
wire [31:0] s_axi_rdata;
btx_output_timing dut_u
(
    .clk, .rst, .host_bit_clock, .tx_enable_in, .clock_gate_enable,
    .diff_encode_enable, .fec_encode_enable, .scrambler_enable,
    .tx_data_in, .aux_clock_out, .symbol_pulse, .bit_clock_out,
    .tx_enable_out, .latched_ctrl, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
);
btx_host_model host_u
(
    .master(m_master), .start(m_start), .bps(m_bps), .bit_clock_out,
    .tx_enable_out, .host_bit_clock, .tx_enable_in, .clock_gate_enable,
    .diff_encode_enable, .fec_encode_enable, .scrambler_enable,
    .tx_data_in
);
initial
begin
    forever
        #50 clk = ~clk;
end
// ========================================
// Checking and closing
task cmp(input [95:0] nm, input [31:0] e, input [31:0] g);
begin
    samples_checked = samples_checked + 1;
    if (g !== e)
    begin
        errors = errors + 1;
        $display("unexpected %0s exp %0h got %0h", nm, e, g);
    end
end
endtask
task summarize;
begin
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
        $display("*** PASS ***");
    else
        $display("*** FAIL ***");
    $finish;
end
endtask
always @(posedge clk)
begin
    cyc = cyc + 1;
    if (cyc == 40000)
    begin
        errors = errors + 1;
        summarize;
    end
end
function [31:0] dly(input [1:0] md, input rs, input [31:0] base);
begin
    dly = base + (rs ? 32'h8 >> md : 32'h0);
end
endfunction
// ========================================
// Bus and scenario tasks
task axi(input wr, input [31:0] a, input [31:0] d);
    reg ok_a, ok_w;
begin
    @(posedge clk);
    ok_a = 1'b0;
    ok_w = !wr;
    s_axi_awaddr <= a[7:0];
    s_axi_araddr <= a[7:0];
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    while (!(ok_a && ok_w))
    begin
        @(posedge clk);
        if (wr ? s_axi_awready : s_axi_arready)
        begin
            ok_a = 1'b1;
            s_axi_awvalid <= 1'b0;
            s_axi_arvalid <= 1'b0;
        end
        if (s_axi_wready && s_axi_wvalid)
        begin
            ok_w = 1'b1;
            s_axi_wvalid <= 1'b0;
        end
    end
    do
        @(posedge clk);
    while (!(wr ? s_axi_bvalid : s_axi_rvalid));
    rq = s_axi_rdata;
    rr = wr ? s_axi_bresp : s_axi_rresp;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
end
endtask
task aux_meas(input [3:0] n);
    integer h, l;
begin
    axi(1'b1, `BTX_REG_AUX_DIV, {28'h0, n});
    repeat (2)
    begin
        while (aux_clock_out)
            @(posedge clk);
        while (!aux_clock_out)
            @(posedge clk);
    end
    for (h = 0; aux_clock_out; h = h + 1)
        @(posedge clk);
    for (l = 0; !aux_clock_out; l = l + 1)
        @(posedge clk);
    cmp("aux_high", 2, h);
    cmp("aux_low", n - 1, l);
end
endtask
task burst(input [1:0] md, input rs);
    integer p;
begin
    axi(1'b1, `BTX_REG_MODE, {md[0] ^ rs, rs, 4'h0, md});
    m_master <= !(md[0] ^ rs);
    m_bps <= md == 2'h0 ? 3'h1 : md == 2'h1 ? 3'h2 : 3'h4;
    m_start <= 1'b1;
    @(posedge clk);
    m_start <= 1'b0;
    while (!tx_enable_in)
        @(posedge clk);
    for (p = 0; !tx_enable_out; p = p + symbol_pulse)
        @(posedge clk);
    cmp("on_delay", dly(md, rs, 2), p);
    while (tx_enable_in)
        @(posedge clk);
    for (p = 0; tx_enable_out; p = p + symbol_pulse)
        @(posedge clk);
    cmp("off_delay", dly(md, rs, 13), p);
end
endtask
// ========================================
// Main sequence
initial
begin
    void'($urandom(32'h081953B1));
    repeat (20)
        @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 3; i = i + 1)
    begin
        axi(1'b0, i * 4, 32'h0);
        cmp("reset_val", i == 0 ? 2 : i == 1 ? 3 : 1, rq);
    end
    axi(1'b0, 32'h10, 32'h0);
    cmp("rd_resp", 2, rr);
    axi(1'b1, 32'h14, 32'h5);
    cmp("wr_resp", 2, rr);
    axi(1'b1, `BTX_REG_BIT_DIV, 32'h7);
    axi(1'b0, `BTX_REG_BIT_DIV, 32'h0);
    cmp("bit_div", 7, rq);
    aux_meas(4'h2);
    aux_meas(4'hF);
    aux_meas(4'h3 + $urandom % 12);
    for (i = 0; i < 6; i = i + 1)
        burst(i / 2, i % 2);
    rst <= 1'b1;
    repeat (2)
        @(posedge clk);
    rst <= 1'b0;
    axi(1'b0, `BTX_REG_MODE, 32'h0);
    cmp("mode_reset", 1, rq);
    summarize;
end
endmodule
